// *** design/fault_restart_pkg.sv ***
// constants, encodings and carrier types of the restart and thermal trip sequencer
package fault_restart_pkg;
	localparam int CLK_NS = 25;
	localparam int TICK_NS = 100_000_000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam logic [7:0] UV_TIME_MIN = 8'h03;
	localparam logic [7:0] UV_TIME_MAX = 8'hFA;
	localparam logic [7:0] UV_TIME_RST = 8'h0A;
	localparam logic [9:0] WAIT_TIME_MIN = 10'h003;
	localparam logic [9:0] WAIT_TIME_MAX = 10'h3E8;
	localparam logic [9:0] WAIT_TIME_RST = 10'h00A;
	localparam logic [1:0] OC_LIMIT = 2'h3;
	localparam logic [1:0] OV_LIMIT = 2'h3;
	localparam logic [4:0] UV_LIMIT = 5'h10;
	localparam int LVL_MIN_PCT = 50;
	localparam int LVL_MAX_PCT = 120;
	localparam int PICKUP_PCT = 115;
	localparam logic [31:0] HEAT_TRIP_RST = 32'h0000_1770;
	localparam logic [31:0] HEAT_COOL = 32'h0000_0001;
	localparam logic [1:0] CURVE_RST = 2'h3;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam int CTRL_RESET_BIT = 2;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_UV_TIME = 8'h04;
	localparam logic [7:0] ADDR_WAIT_TIME = 8'h08;
	localparam logic [7:0] ADDR_LEVEL1 = 8'h0C;
	localparam logic [7:0] ADDR_LEVEL2 = 8'h10;
	localparam logic [7:0] ADDR_CURVE = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_HISTORY = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h24;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h28;
	// fault codes logged in the history
	localparam logic [7:0] CODE_OC = 8'h01;
	localparam logic [7:0] CODE_THERMAL = 8'h05;
	localparam logic [7:0] CODE_OV = 8'h07;
	localparam logic [7:0] CODE_UV = 8'h09;
	localparam logic [7:0] CODE_PWR_FAIL = 8'h0A;
	typedef enum logic [1:0] {
		MODE_ALARM = 2'h0,
		MODE_ZERO = 2'h1,
		MODE_MATCH = 2'h2,
		MODE_MATCH_STOP = 2'h3
	} restartMode_t;
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_UVRIDE = 6'h02,
		ST_WAIT = 6'h04,
		ST_RESTART = 6'h08,
		ST_ALARM = 6'h10,
		ST_LOCK = 6'h20
	} state_t;
	typedef struct packed {
		logic overCurrent;
		logic overVoltage;
		logic underVoltage;
	} powerEvt_t;
	typedef struct packed {
		logic thermal;
		logic lockout;
		logic restart;
		logic trip;
	} irqBits_t;
	typedef struct packed {
		logic [1:0] ocCnt;
		logic [1:0] ovCnt;
		logic [4:0] uvCnt;
	} retryCnt_t;
endpackage

// *** design/fault_restart_thermal_trip.sv ***
// restart sequencer with retry lockout and inverse-time thermal overload trip
//
// Functional notes
// - over-current trip restarts automatically at most three times in restart modes
// - over-voltage trip restarts automatically at most three times in restart modes
// - under-voltage trip restarts automatically at most sixteen times in restart modes
// - retry limit used up: stop restarting, stay tripped until power cycle
// - mode 00 alarm only, 01 from 0 Hz, 02 match, 03 match then stop
// - matching restart uses motor speed estimated from residual flux
// - under-voltage tolerated 0.3 to 25 s; longer trips power failure anyway
// - wait 0.3 to 100 s after under-voltage clears before running again
// - thermal trip time falls as output current rises
// - thermal threshold in 0.01 A, 50% to 120% of drive rated current
// - thermal trip logs thermal overload code in fault history
// - any trip switches motor output off
// - curve select: 00 reduced torque, 01 constant torque
// - second motor has its own threshold and curve, used when selected
// - threshold at full load rating trips at about 115% sustained current
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module fault_restart_thermal_trip #(
	parameter int TICK_CYCLES = fault_restart_pkg::TICK_CYCLES,
	parameter logic [15:0] RATED_CURRENT = 16'h012C,
	parameter logic [31:0] HEAT_TRIP = fault_restart_pkg::HEAT_TRIP_RST
) (
	input wire logic clk, // 40 MHz
	input wire logic rst, // async, high
	input wire logic [7:0] addr, // register byte address
	input wire logic [31:0] wdata, // write data
	input wire logic we, // write strobe
	input wire logic re, // read strobe
	output logic [31:0] rdata, // read data, cycle after re
	input wire fault_restart_pkg::powerEvt_t powerEvt, // trip causes from power stage
	input wire logic [15:0] motorCurrent, // output current, 0.01 A
	input wire logic [15:0] speedEstimate, // flux speed estimate, 0.1 Hz
	input wire logic motorSel, // second motor in use
	output logic motorOn, // motor output enabled
	output logic restartPulse, // one-cycle restart request
	output logic [15:0] restartFreq, // start frequency, 0.1 Hz
	output logic decelStop, // decelerate to stop after resume
	output logic alarmOut, // alarm output
	output logic lockout, // retries used up
	output logic irq // level interrupt
);
	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] LVL_LO = 16'((32'(RATED_CURRENT) * fault_restart_pkg::LVL_MIN_PCT) / 100);
	localparam logic [15:0] LVL_HI = 16'((32'(RATED_CURRENT) * fault_restart_pkg::LVL_MAX_PCT) / 100);

	fault_restart_pkg::state_t state_q, state_d;
	fault_restart_pkg::retryCnt_t cnt_q, cnt_d;
	fault_restart_pkg::irqBits_t evt, irqStat_q, irqStat_d, irqEn_q, irqEn_d;
	logic [1:0] mode_q, mode_d, curve_q, curve_d;
	logic [7:0] uvTime_q, uvTime_d, uvTimer_q, uvTimer_d;
	logic [9:0] waitTime_q, waitTime_d, waitTimer_q, waitTimer_d;
	logic [15:0] lvl1_q, lvl1_d, lvl2_q, lvl2_d;
	logic [21:0] tickCnt_q, tickCnt_d;
	logic tick_q, tick_d;
	logic [31:0] heat_q, heat_d;
	logic [7:0] hist_q [4];
	logic [7:0] hist_d [4];
	logic [7:0] newCode;
	logic logCode, faultReset, thermTrip;
	logic [15:0] activeLvl;
	logic activeCurve;
	logic [23:0] pickup;
	logic [15:0] excess;
	logic [31:0] rdata_d;
	logic motorOn_d, restartPulse_d, decelStop_d, alarmOut_d, lockout_d, irq_d;
	logic [15:0] restartFreq_d;

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// register file and interrupts
	assign faultReset = we && (addr == fault_restart_pkg::ADDR_CTRL) && wdata[fault_restart_pkg::CTRL_RESET_BIT];

	always_comb begin
		mode_d = mode_q;
		curve_d = curve_q;
		uvTime_d = uvTime_q;
		waitTime_d = waitTime_q;
		lvl1_d = lvl1_q;
		lvl2_d = lvl2_q;
		irqEn_d = irqEn_q;
		irqStat_d = irqStat_q;
		rdata_d = 32'h0000_0000;
		if (we) begin
			if (addr == fault_restart_pkg::ADDR_CTRL) begin
				mode_d = wdata[1:0];
			end else if (addr == fault_restart_pkg::ADDR_UV_TIME) begin
				uvTime_d = 8'(clamp16(16'(wdata[7:0]), 16'(fault_restart_pkg::UV_TIME_MIN),
					16'(fault_restart_pkg::UV_TIME_MAX)));
			end else if (addr == fault_restart_pkg::ADDR_WAIT_TIME) begin
				waitTime_d = 10'(clamp16(16'(wdata[9:0]), 16'(fault_restart_pkg::WAIT_TIME_MIN),
					16'(fault_restart_pkg::WAIT_TIME_MAX)));
			end else if (addr == fault_restart_pkg::ADDR_LEVEL1) begin
				lvl1_d = clamp16(wdata[15:0], LVL_LO, LVL_HI);
			end else if (addr == fault_restart_pkg::ADDR_LEVEL2) begin
				lvl2_d = clamp16(wdata[15:0], LVL_LO, LVL_HI);
			end else if (addr == fault_restart_pkg::ADDR_CURVE) begin
				curve_d = wdata[1:0];
			end else if (addr == fault_restart_pkg::ADDR_IRQ_CLR) begin
				irqStat_d = irqStat_q & ~wdata[3:0];
			end else if (addr == fault_restart_pkg::ADDR_IRQ_EN) begin
				irqEn_d = wdata[3:0];
			end
		end
		// a new event outranks a clear in the same cycle
		irqStat_d = irqStat_d | evt;
		if (re) begin
			if (addr == fault_restart_pkg::ADDR_CTRL) begin
				rdata_d = {30'h0, mode_q};
			end else if (addr == fault_restart_pkg::ADDR_UV_TIME) begin
				rdata_d = {24'h0, uvTime_q};
			end else if (addr == fault_restart_pkg::ADDR_WAIT_TIME) begin
				rdata_d = {22'h0, waitTime_q};
			end else if (addr == fault_restart_pkg::ADDR_LEVEL1) begin
				rdata_d = {16'h0, lvl1_q};
			end else if (addr == fault_restart_pkg::ADDR_LEVEL2) begin
				rdata_d = {16'h0, lvl2_q};
			end else if (addr == fault_restart_pkg::ADDR_CURVE) begin
				rdata_d = {30'h0, curve_q};
			end else if (addr == fault_restart_pkg::ADDR_STATUS) begin
				rdata_d = {17'h0, cnt_q, state_q};
			end else if (addr == fault_restart_pkg::ADDR_HISTORY) begin
				rdata_d = {hist_q[3], hist_q[2], hist_q[1], hist_q[0]};
			end else if (addr == fault_restart_pkg::ADDR_IRQ_STAT) begin
				rdata_d = {28'h0, irqStat_q};
			end else if (addr == fault_restart_pkg::ADDR_IRQ_EN) begin
				rdata_d = {28'h0, irqEn_q};
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= fault_restart_pkg::MODE_RST;
			curve_q <= fault_restart_pkg::CURVE_RST;
			uvTime_q <= fault_restart_pkg::UV_TIME_RST;
			waitTime_q <= fault_restart_pkg::WAIT_TIME_RST;
			lvl1_q <= RATED_CURRENT;
			lvl2_q <= RATED_CURRENT;
			irqEn_q <= '0;
			irqStat_q <= '0;
			rdata <= 32'h0000_0000;
		end else begin
			mode_q <= mode_d;
			curve_q <= curve_d;
			uvTime_q <= uvTime_d;
			waitTime_q <= waitTime_d;
			lvl1_q <= lvl1_d;
			lvl2_q <= lvl2_d;
			irqEn_q <= irqEn_d;
			irqStat_q <= irqStat_d;
			rdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// thermal model, 100 ms tick
	always_comb begin
		activeLvl = motorSel ? lvl2_q : lvl1_q;
		activeCurve = motorSel ? curve_q[1] : curve_q[0];
		pickup = 24'((32'(activeLvl) * fault_restart_pkg::PICKUP_PCT) / 100);
		excess = ({8'h00, motorCurrent} > pickup) ? 16'(24'(motorCurrent) - pickup) : 16'h0000;
		tickCnt_d = (tickCnt_q == 22'(TICK_CYCLES - 1)) ? 22'h0 : tickCnt_q + 22'h1;
		tick_d = (tickCnt_q == 22'(TICK_CYCLES - 1));
		heat_d = heat_q;
		if (faultReset && (state_q == fault_restart_pkg::ST_ALARM)) begin
			heat_d = 32'h0000_0000;
		end else if (tick_q) begin
			if (excess != 16'h0000) begin
				// heat rate rises with excess current, so trip time falls
				// reduced-torque curve heats twice as fast, weaker self-cooling
				heat_d = heat_q + (activeCurve ? 32'(excess) : {15'h0, excess, 1'b0});
			end else if (heat_q >= fault_restart_pkg::HEAT_COOL) begin
				heat_d = heat_q - fault_restart_pkg::HEAT_COOL;
			end else begin
				heat_d = 32'h0000_0000;
			end
		end
		thermTrip = (heat_q >= HEAT_TRIP);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tickCnt_q <= 22'h0;
			tick_q <= 1'b0;
			heat_q <= 32'h0000_0000;
		end else begin
			tickCnt_q <= tickCnt_d;
			tick_q <= tick_d;
			heat_q <= heat_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// restart sequencer
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		uvTimer_d = uvTimer_q;
		waitTimer_d = waitTimer_q;
		newCode = 8'h00;
		logCode = 1'b0;
		evt = '0;
		restartPulse_d = 1'b0;
		restartFreq_d = restartFreq;
		decelStop_d = decelStop;
		case (state_q)
			fault_restart_pkg::ST_RUN: begin
				if (thermTrip) begin
					// thermal trip logged, no automatic restart
					newCode = fault_restart_pkg::CODE_THERMAL;
					logCode = 1'b1;
					evt.thermal = 1'b1;
					state_d = fault_restart_pkg::ST_ALARM;
				end else if (powerEvt.overCurrent || powerEvt.overVoltage) begin
					logCode = 1'b1;
					newCode = powerEvt.overCurrent ? fault_restart_pkg::CODE_OC : fault_restart_pkg::CODE_OV;
					waitTimer_d = 10'h000;
					if (mode_q == fault_restart_pkg::MODE_ALARM) begin
						state_d = fault_restart_pkg::ST_ALARM;
					end else if (powerEvt.overCurrent) begin
						if (cnt_q.ocCnt < fault_restart_pkg::OC_LIMIT) begin
							cnt_d.ocCnt = cnt_q.ocCnt + 2'h1;
							state_d = fault_restart_pkg::ST_WAIT;
						end else begin
							state_d = fault_restart_pkg::ST_LOCK;
						end
					end else begin
						if (cnt_q.ovCnt < fault_restart_pkg::OV_LIMIT) begin
							cnt_d.ovCnt = cnt_q.ovCnt + 2'h1;
							state_d = fault_restart_pkg::ST_WAIT;
						end else begin
							state_d = fault_restart_pkg::ST_LOCK;
						end
					end
				end else if (powerEvt.underVoltage) begin
					uvTimer_d = 8'h00;
					state_d = fault_restart_pkg::ST_UVRIDE;
				end
			end
			fault_restart_pkg::ST_UVRIDE: begin
				if (!powerEvt.underVoltage) begin
					waitTimer_d = 10'h000;
					logCode = 1'b1;
					newCode = fault_restart_pkg::CODE_UV;
					if (mode_q == fault_restart_pkg::MODE_ALARM) begin
						state_d = fault_restart_pkg::ST_ALARM;
					end else if (cnt_q.uvCnt < fault_restart_pkg::UV_LIMIT) begin
						// count the attempt on its own counter
						cnt_d.uvCnt = cnt_q.uvCnt + 5'h01;
						state_d = fault_restart_pkg::ST_WAIT;
					end else begin
						state_d = fault_restart_pkg::ST_LOCK;
					end
				end else if (tick_q) begin
					uvTimer_d = uvTimer_q + 8'h01;
					// too long: power failure trip whatever the mode
					if (uvTimer_d >= uvTime_q) begin
						logCode = 1'b1;
						newCode = fault_restart_pkg::CODE_PWR_FAIL;
						state_d = fault_restart_pkg::ST_ALARM;
					end
				end
			end
			fault_restart_pkg::ST_WAIT: begin
				if (powerEvt.underVoltage) begin
					uvTimer_d = 8'h00;
					state_d = fault_restart_pkg::ST_UVRIDE;
				end else if (tick_q) begin
					waitTimer_d = waitTimer_q + 10'h001;
					if (waitTimer_d >= waitTime_q) begin
						state_d = fault_restart_pkg::ST_RESTART;
					end
				end
			end
			fault_restart_pkg::ST_RESTART: begin
				restartPulse_d = 1'b1;
				evt.restart = 1'b1;
				// start frequency and stop behaviour per mode
				// matching modes restart at the estimated speed
				restartFreq_d = (mode_q == fault_restart_pkg::MODE_ZERO) ? 16'h0000 : speedEstimate;
				decelStop_d = (mode_q == fault_restart_pkg::MODE_MATCH_STOP);
				state_d = fault_restart_pkg::ST_RUN;
			end
			fault_restart_pkg::ST_ALARM: begin
				if (faultReset) begin
					state_d = fault_restart_pkg::ST_RUN;
				end
			end
			default: begin
				// only a power cycle leaves lockout
				state_d = fault_restart_pkg::ST_LOCK;
			end
		endcase
		if (logCode) begin
			evt.trip = 1'b1;
		end
		if ((state_d == fault_restart_pkg::ST_LOCK) && (state_q != fault_restart_pkg::ST_LOCK)) begin
			evt.lockout = 1'b1;
		end
		hist_d[0] = logCode ? newCode : hist_q[0];
		for (int i = 1; i < 4; i++) begin
			hist_d[i] = logCode ? hist_q[i - 1] : hist_q[i];
		end
		// output off in every tripped state
		motorOn_d = (state_d == fault_restart_pkg::ST_RUN) || (state_d == fault_restart_pkg::ST_RESTART);
		alarmOut_d = (state_d == fault_restart_pkg::ST_ALARM) || (state_d == fault_restart_pkg::ST_LOCK);
		lockout_d = (state_d == fault_restart_pkg::ST_LOCK);
		irq_d = |(irqStat_d & irqEn_d);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= fault_restart_pkg::ST_RUN;
			cnt_q <= '0;
			uvTimer_q <= 8'h00;
			waitTimer_q <= 10'h000;
			for (int i = 0; i < 4; i++) begin
				hist_q[i] <= 8'h00;
			end
			motorOn <= 1'b0;
			restartPulse <= 1'b0;
			restartFreq <= 16'h0000;
			decelStop <= 1'b0;
			alarmOut <= 1'b0;
			lockout <= 1'b0;
			irq <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			uvTimer_q <= uvTimer_d;
			waitTimer_q <= waitTimer_d;
			hist_q <= hist_d;
			motorOn <= motorOn_d;
			restartPulse <= restartPulse_d;
			restartFreq <= restartFreq_d;
			decelStop <= decelStop_d;
			alarmOut <= alarmOut_d;
			lockout <= lockout_d;
			irq <= irq_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	oc_retry_bound_a: assert property (cnt_q.ocCnt == fault_restart_pkg::OC_LIMIT && state_q == fault_restart_pkg::ST_RUN
		&& !thermTrip && powerEvt.overCurrent && mode_q != fault_restart_pkg::MODE_ALARM
		|=> state_q == fault_restart_pkg::ST_LOCK) else $error("over-current retry past limit");
	ov_retry_bound_a: assert property (cnt_q.ovCnt <= fault_restart_pkg::OV_LIMIT && $stable(cnt_q.ovCnt)
		or $past(state_q) == fault_restart_pkg::ST_RUN) else $error("over-voltage counter moved outside a trip");
	uv_retry_bound_a: assert property (cnt_q.uvCnt <= fault_restart_pkg::UV_LIMIT)
		else $error("under-voltage retries exceed limit");
	lockout_hold_a: assert property (state_q == fault_restart_pkg::ST_LOCK |=> lockout && !motorOn [*3])
		else $error("lockout released");
	zero_start_a: assert property (state_q == fault_restart_pkg::ST_RESTART && mode_q == fault_restart_pkg::MODE_ZERO
		|=> restartPulse && restartFreq == 16'h0000) else $error("zero-hertz restart not at zero");
	match_start_a: assert property (state_q == fault_restart_pkg::ST_RESTART && mode_q != fault_restart_pkg::MODE_ZERO
		|=> restartFreq == $past(speedEstimate)) else $error("matching restart frequency wrong");
	uv_trip_time_a: assert property (state_q == fault_restart_pkg::ST_UVRIDE && powerEvt.underVoltage && tick_q
		&& uvTimer_q + 8'h01 >= uvTime_q |=> state_q == fault_restart_pkg::ST_ALARM
		&& hist_q[0] == fault_restart_pkg::CODE_PWR_FAIL)
		else $error("under-voltage not tripped after tolerance");
	wait_hold_a: assert property (state_q == fault_restart_pkg::ST_WAIT && !tick_q
		|=> state_q != fault_restart_pkg::ST_RESTART) else $error("restart without wait tick");
	level_range_a: assert property (lvl1_q >= LVL_LO && lvl1_q <= LVL_HI && lvl2_q >= LVL_LO && lvl2_q <= LVL_HI)
		else $error("thermal threshold out of range");
	thermal_log_a: assert property (state_q == fault_restart_pkg::ST_RUN && thermTrip
		|=> hist_q[0] == fault_restart_pkg::CODE_THERMAL && !motorOn && irqStat_q.thermal)
		else $error("thermal trip not logged");
	motor_off_a: assert property (state_q inside {fault_restart_pkg::ST_ALARM, fault_restart_pkg::ST_LOCK,
		fault_restart_pkg::ST_UVRIDE, fault_restart_pkg::ST_WAIT} |-> !motorOn) else $error("motor on while tripped");

	lockout_seen_c: cover property (state_q == fault_restart_pkg::ST_LOCK);
	restart_seen_c: cover property (restartPulse && decelStop);
	thermal_seen_c: cover property (thermTrip && motorSel);
	uv_ride_c: cover property (state_q == fault_restart_pkg::ST_UVRIDE ##1 state_q == fault_restart_pkg::ST_WAIT);
endmodule
`default_nettype wire

// *** dv/motor_power_model.sv ***
// motor and power input stage stand-in, faults raised on bench request
`timescale 1ns/1ps
`default_nettype none
module motor_power_model (
	input wire logic clk, // drive clock
	input wire logic motorOn, // drive output enabled
	input wire logic ocReq, // raise over-current
	input wire logic ovReq, // raise over-voltage
	input wire logic uvReq, // sag the supply
	input wire logic [15:0] load, // current drawn while driven
	input wire logic [15:0] coast, // running speed
	output var fault_restart_pkg::powerEvt_t powerEvt, // trip causes
	output logic [15:0] motorCurrent, // output current
	output logic [15:0] speedEstimate // residual flux speed
);
	logic [9:0] div = 10'h000;
	logic [15:0] speed = 16'h0000;
	// current and load faults only exist while the output drives the motor
	assign motorCurrent = motorOn ? load : 16'h0000;
	assign powerEvt = {ocReq & motorOn, ovReq & motorOn, uvReq};
	assign speedEstimate = speed;
	// a coasting motor slows slowly, so the flux reading drifts down
	always_ff @(posedge clk) begin
		div <= div + 10'h001;
		if (motorOn)
			speed <= coast;
		else if (div == 10'h000 && speed != 16'h0000)
			speed <= speed - 16'h0001;
	end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// self-checking bench for the restart sequencer and thermal trip
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TK = 10;
	localparam int HEAT = 2000;
	logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, motorSel = 1'b0;
	logic ocReq = 1'b0, ovReq = 1'b0, uvReq = 1'b0;
	logic motorOn, restartPulse, decelStop, alarmOut, lockout, irq;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata, rv;
	logic [15:0] load = 16'h0000, coast = 16'h0100, motorCurrent, speedEstimate, restartFreq;
	fault_restart_pkg::powerEvt_t powerEvt;
	int miscompares = 0, checks_done = 0, t, ex, m;
	int histQ[$];
	logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h28, 8'h3C};
	logic [31:0] rr[8] = '{32'h0, 32'h0A, 32'h0A, 32'h12C, 32'h12C, 32'h3, 32'h0, 32'h0};
	logic [7:0] ca[5] = '{8'h04, 8'h04, 8'h08, 8'h0C, 8'h0C};
	logic [31:0] cw[5] = '{32'h0, 32'hFF, 32'hFFFF, 32'h0, 32'hFFFF};
	logic [31:0] ce[5] = '{32'h3, 32'hFA, 32'h3E8, 32'h96, 32'h168};
	int md[5] = '{0, 1, 2, 3, 1};
	always #12.5 clk = ~clk;
	fault_restart_thermal_trip #(.TICK_CYCLES(TK), .RATED_CURRENT(16'h012C), .HEAT_TRIP(32'h0000_07D0))
	i_fault_restart_thermal_trip (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
		.rdata(rdata), .powerEvt(powerEvt), .motorCurrent(motorCurrent), .speedEstimate(speedEstimate),
		.motorSel(motorSel), .motorOn(motorOn), .restartPulse(restartPulse), .restartFreq(restartFreq),
		.decelStop(decelStop), .alarmOut(alarmOut), .lockout(lockout), .irq(irq));
	motor_power_model i_motor_power_model (.clk(clk), .motorOn(motorOn), .ocReq(ocReq), .ovReq(ovReq),
		.uvReq(uvReq), .load(load), .coast(coast), .powerEvt(powerEvt), .motorCurrent(motorCurrent),
		.speedEstimate(speedEstimate));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask
	task automatic results;
		$display("counts: %0d checks, %0d mismatches", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		@(negedge clk);
		rv = rdata;
	endtask
	// count cycles until restart (0) or alarm (1) shows; an expired bound ends the run
	task automatic waitHi(input int which, input int lim);
		t = 0;
		while (!(which == 0 ? restartPulse === 1'b1 : alarmOut === 1'b1)) begin
			@(negedge clk);
			t++;
			if (t > lim) begin
				$display("mismatch at %0t: wait expired, got %h expected %h", $time, 1'b0, 1'b1);
				miscompares++;
				results();
			end
		end
	endtask
	task automatic doReset;
		rst <= 1'b1;
		cyc(8);
		rst <= 1'b0;
		cyc(1);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		if (k == 0)
			ocReq <= 1'b1;
		else
			ovReq <= 1'b1;
		@(posedge clk);
		ocReq <= 1'b0;
		ovReq <= 1'b0;
		cyc(2);
	endtask
	// heat starts cold after fault reset; trip time predicted in whole ticks
	task automatic heatRun(input logic [15:0] ld, input int pick, input int k);
		wr(8'h00, 32'h4);
		@(posedge clk);
		load <= ld;
		waitHi(1, 200 * TK);
		@(posedge clk);
		load <= 16'h0000;
		ex = (HEAT + (ld - pick) * k - 1) / ((ld - pick) * k);
		chk(t / TK >= ex - 1 && t / TK <= ex + 1, 1);
		chk(motorOn, 0);
		histQ.push_back(8'h05);
		rd(8'h1C);
		chk(rv[7:0], histQ[$]);
	endtask
	initial begin
		void'($urandom(76242));
		doReset();
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(rv, rr[i]);
		end
		foreach (ca[i]) begin
			wr(ca[i], cw[i]);
			rd(ca[i]);
			chk(rv, ce[i]);
		end
		$display("test registers done");
		wr(8'h00, 32'h1);
		wr(8'h08, 32'h0);
		for (int i = 0; i < 4; i++) begin
			pulse(0);
			chk(motorOn, 0);
			if (i == 0) begin
				rd(8'h20);
				chk({rv[0], irq}, 2'b10);
				wr(8'h28, 32'hF);
				cyc(2);
				chk(irq, 1);
				wr(8'h24, 32'hF);
				cyc(2);
				chk(irq, 0);
			end
			if (i < 3) begin
				waitHi(0, 10 * TK);
				chk(restartFreq, 0);
				rd(8'h18);
				chk(rv[14:13], i + 1);
			end
		end
		cyc(20 * TK);
		chk({lockout, alarmOut, motorOn, irq}, 4'b1101);
		$display("test over-current done");
		doReset();
		wr(8'h08, 32'h0);
		for (int i = 0; i < 5; i++) begin
			m = md[i];
			wr(8'h00, m);
			@(posedge clk);
			coast <= 16'($urandom_range(256, 3840));
			cyc(4);
			pulse(1);
			chk(motorOn, 0);
			if (m == 0) begin
				cyc(20 * TK);
				chk({alarmOut, motorOn}, 2'b10);
				wr(8'h00, 32'h4);
				cyc(2);
				chk({alarmOut, motorOn}, 2'b01);
			end else if (i < 4) begin
				waitHi(0, 10 * TK);
				if (m == 1)
					chk(restartFreq, 0);
				else
					chk(restartFreq == speedEstimate || restartFreq == speedEstimate + 16'h0001, 1);
				chk(decelStop, m == 3);
				rd(8'h18);
				chk(rv[12:11], i);
			end
		end
		cyc(20 * TK);
		chk(lockout, 1);
		$display("test over-voltage and modes done");
		doReset();
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h3);
		wr(8'h08, 32'h0);
		for (int i = 0; i < 17; i++) begin
			@(posedge clk);
			uvReq <= 1'b1;
			cyc($urandom_range(11, 19));
			uvReq <= 1'b0;
			if (i < 16) begin
				waitHi(0, 10 * TK);
				chk(t >= 2 * TK, 1);
				rd(8'h18);
				chk(rv[10:6], i + 1);
			end
		end
		cyc(20 * TK);
		chk(lockout, 1);
		doReset();
		wr(8'h00, 32'h1);
		wr(8'h04, 32'h3);
		@(posedge clk);
		uvReq <= 1'b1;
		waitHi(1, 6 * TK);
		chk(t >= 2 * TK, 1);
		@(posedge clk);
		uvReq <= 1'b0;
		histQ.push_back(8'h0A);
		rd(8'h1C);
		chk(rv[7:0], histQ[$]);
		$display("test under-voltage done");
		doReset();
		@(posedge clk);
		load <= 16'd340;
		cyc(100 * TK);
		chk(alarmOut, 0);
		heatRun(16'd400, 345, 1);
		heatRun(16'd500, 345, 1);
		wr(8'h14, 32'h2);
		heatRun(16'd400, 345, 2);
		wr(8'h10, 32'h96);
		@(posedge clk);
		motorSel <= 1'b1;
		heatRun(16'd272, 172, 1);
		$display("test thermal done");
		results();
	end
endmodule
`default_nettype wire
